/* logic/uart_pkg.sv */
// Purpose: shared constants and carriers for the async serial engine
// Assumes: one clock, synchronous active-high reset
// Notes:   serial clock is ref_clk or a divided tick from outside

package uart_pkg;

   // sampling: 16 serial clocks per bit, start check at 8
   localparam int unsigned OVERSAMPLE   = 16;
   localparam int unsigned HALF_BIT     = 8;
   localparam logic [3:0]  OVS_LAST     = 4'hF;
   localparam logic [3:0]  OVS_MID      = 4'h7;

   // mode field encodings
   localparam logic [1:0]  PAR_NONE     = 2'h0;
   localparam logic [1:0]  PAR_ZERO     = 2'h1;
   localparam logic [1:0]  PAR_ODD      = 2'h2;
   localparam logic [1:0]  PAR_EVEN     = 2'h3;

   // data width, FIFO depth, receive buffer reset value
   localparam int unsigned CHAR_W       = 9;
   localparam int unsigned FIFO_DEPTH   = 16;
   localparam logic [8:0]  RX_BUF_RESET = 9'h000;

   typedef struct packed {
      logic       rx_enable_bit;
      logic [1:0] parity_select;
      logic       char_length_sel;
      logic       stop_length_sel;
      logic       ninth_bit_enable;
   } async_mode_t;

   typedef struct packed {
      logic parity_err_flag;
      logic framing_err_flag;
      logic overrun_err_flag;
   } async_error_t;

   typedef enum logic [2:0] {
      TX_IDLE   = 3'h0,
      TX_START  = 3'h1,
      TX_DATA   = 3'h3,
      TX_PARITY = 3'h2,
      TX_STOP   = 3'h6
   } tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE   = 3'h0,
      RX_START  = 3'h1,
      RX_DATA   = 3'h3,
      RX_PARITY = 3'h2,
      RX_STOP   = 3'h6
   } rx_state_t;

endpackage

/* logic/sync_fifo.sv */
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: one clock, synchronous reset
// Notes:   full and empty derived from a count, no bypass path

`timescale 1ns/1ps
`default_nettype none

module sync_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 16
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             reset,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   wire              push;
   wire              pop;

   assign in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr_reg];

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule

`default_nettype wire

/* logic/bit_sync.sv */
// Purpose: two-flop synchroniser for one level
// Assumes: destination clock ref_clk
// Notes:   resets to the idle-high line level

`timescale 1ns/1ps
`default_nettype none

module bit_sync (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic reset,
   // level
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_reg;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         meta_reg <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

`default_nettype wire

/* logic/async_serial_uart_engine.sv */
// Purpose: full-duplex asynchronous serial transmitter and receiver
// Assumes: serial_tick is a one-cycle pulse per serial clock (16x bit rate)
// Notes:   tx writes pass a 16-word FIFO; the frame engine drains one word
//          only when idle; writes while tx_busy is high never reach the FIFO

`timescale 1ns/1ps
`default_nettype none


// Contract
// - frame is start, 7/8/9 char bits, optional parity, one or two stops.
// - written word launches a frame, start bit then LSB first, framing added.
// - transmitter always enabled, no enable input exists.
// - after a full frame, pulse transmit-complete; line stays idle if nothing new.
// - writes during a frame before transmit-complete are discarded.
// - reset empties the transmitter without a transmit-complete pulse.
// - receive enable low resets receiver, keeps buffer, blocks receive interrupts.
// - re-sample eight serial clocks after falling edge, then every sixteen.
// - high at mid-start rejects edge, halts counter, awaits next edge.
// - completed frame with receiver enabled loads buffer, then receive-complete.
// - errored frame still loads buffer and raises both receive interrupts.
// - clearing enable mid-frame aborts, keeps buffer and status, no interrupts.
// - receive-error interrupt is the OR of parity, framing, overrun flags; code pulses it only in the receive-complete cycle, with receive enabled.
// - error flags clear on buffer read or next frame; new errors set them.
// - parity error when received parity bit disagrees with configured parity.
// - framing error when expected stop bit is not high.
// - overrun when a frame completes before previous character was read.
// - interrupt priority is receive-error, receive-complete, then transmit-complete.
// - ninth bit only with no parity and extended-bit enable set.
// - unused upper buffer bits read zero for 7- or 8-bit characters.
// - receiver samples at sixteen times bit rate.
module async_serial_uart_engine
   import uart_pkg::*;
(
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         reset,
   // configuration
   input  wire async_mode_t  async_mode_reg,
   input  wire logic         serial_tick,
   // transmit word
   input  wire logic         tx_write,
   input  wire logic [8:0]   tx_shift_word,
   output logic              tx_write_ready,
   output logic              tx_busy,
   // receive buffer
   input  wire logic         rx_buffer_read,
   output logic [8:0]        rx_buffer_word,
   output logic [7:0]        rx_buffer_low_byte,
   output async_error_t      async_error_status,
   // interrupts
   output logic              tx_done_irq,
   output logic              rx_done_irq,
   output logic              rx_error_irq,
   output logic [1:0]        irq_top_priority,
   // serial line
   output logic              txd,
   input  wire logic         rxd
);
   // decoded mode
   wire       par_on;
   wire       ninth_on;
   wire [3:0] char_bits;
   assign par_on    = (async_mode_reg.parity_select != PAR_NONE);
   assign ninth_on  = !par_on && async_mode_reg.ninth_bit_enable;
   assign char_bits = ninth_on ? 4'h9 : (async_mode_reg.char_length_sel ? 4'h8 : 4'h7);

   // transmit path ------------------------------------------------------
   wire        fifo_valid;
   wire [8:0]  fifo_data;
   wire        fifo_pop;
   tx_state_t  tx_state_reg;
   logic [3:0] tx_ovs_reg;
   logic [3:0] tx_cnt_reg;
   logic [8:0] tx_sh_reg;
   logic       tx_par_reg;
   logic       tx_stop2_reg;
   wire        tx_bit_end;

   wire fifo_in_valid = tx_write && !tx_busy;

   sync_fifo #(
      .WIDTH (CHAR_W),
      .DEPTH (FIFO_DEPTH)
   ) tx_fifo (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .in_valid  (fifo_in_valid),
      .in_ready  (tx_write_ready),
      .in_data   (tx_shift_word),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   assign fifo_pop   = (tx_state_reg == TX_IDLE);
   assign tx_bit_end = serial_tick && (tx_ovs_reg == OVS_LAST);

   // busy from accepted write until the frame-complete pulse
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tx_busy <= 1'b0;
      end else if (tx_done_irq) begin
         tx_busy <= 1'b0;
      end else if (fifo_in_valid && tx_write_ready) begin
         tx_busy <= 1'b1;
      end
   end

   function automatic logic [8:0] char_mask(input logic [3:0] n);
      char_mask = (n == 4'h9) ? 9'h1FF : ((n == 4'h8) ? 9'h0FF : 9'h07F);
   endfunction

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tx_state_reg <= TX_IDLE;
         tx_ovs_reg   <= '0;
         tx_cnt_reg   <= '0;
         tx_sh_reg    <= '0;
         tx_par_reg   <= 1'b0;
         tx_stop2_reg <= 1'b0;
         txd          <= 1'b1;
         tx_done_irq  <= 1'b0;
      end else begin
         tx_done_irq <= 1'b0;
         if (serial_tick && tx_state_reg != TX_IDLE) begin
            tx_ovs_reg <= tx_ovs_reg + 4'h1;
         end
         case (tx_state_reg)
            TX_IDLE: begin
               txd <= 1'b1;
               if (fifo_valid) begin
                  tx_sh_reg    <= fifo_data & char_mask(char_bits);
                  tx_stop2_reg <= async_mode_reg.stop_length_sel;
                  tx_ovs_reg   <= '0;
                  txd          <= 1'b0;
                  tx_state_reg <= TX_START;
                  case (async_mode_reg.parity_select)
                     PAR_ODD:  tx_par_reg <= ~^(fifo_data & char_mask(char_bits));
                     PAR_EVEN: tx_par_reg <= ^(fifo_data & char_mask(char_bits));
                     default:  tx_par_reg <= 1'b0;
                  endcase
               end
            end
            TX_START: begin
               if (tx_bit_end) begin
                  txd          <= tx_sh_reg[0];
                  tx_sh_reg    <= {1'b0, tx_sh_reg[8:1]};
                  tx_cnt_reg   <= char_bits - 4'h1;
                  tx_state_reg <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (tx_bit_end) begin
                  if (tx_cnt_reg != 4'h0) begin
                     txd        <= tx_sh_reg[0];
                     tx_sh_reg  <= {1'b0, tx_sh_reg[8:1]};
                     tx_cnt_reg <= tx_cnt_reg - 4'h1;
                  end else if (par_on) begin
                     txd          <= tx_par_reg;
                     tx_state_reg <= TX_PARITY;
                  end else begin
                     txd          <= 1'b1;
                     tx_state_reg <= TX_STOP;
                  end
               end
            end
            TX_PARITY: begin
               if (tx_bit_end) begin
                  txd          <= 1'b1;
                  tx_state_reg <= TX_STOP;
               end
            end
            TX_STOP: begin
               if (tx_bit_end) begin
                  if (tx_stop2_reg) begin
                     tx_stop2_reg <= 1'b0;
                  end else begin
                     tx_done_irq  <= 1'b1;
                     tx_state_reg <= TX_IDLE;
                  end
               end
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   // receive path -------------------------------------------------------
   wire        rxd_s;
   logic       rxd_prev_reg;
   rx_state_t  rx_state_reg;
   logic [3:0] rx_ovs_reg;
   logic [3:0] rx_cnt_reg;
   logic [8:0] rx_sh_reg;
   logic       rx_par_reg;
   logic       rx_stop2_reg;
   logic       rx_unread_reg;
   wire        rx_sample;
   wire        rx_fall;
   wire        rx_enable;

   bit_sync rxd_sync (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .async_in (rxd),
      .sync_out (rxd_s)
   );

   assign rx_enable = async_mode_reg.rx_enable_bit;
   assign rx_fall   = rxd_prev_reg && !rxd_s;
   assign rx_sample = serial_tick && (rx_ovs_reg == OVS_MID);

   // received parity mismatch for the configured mode
   wire par_bad;
   assign par_bad = (async_mode_reg.parity_select == PAR_ZERO) ? rxd_s :
                    (async_mode_reg.parity_select == PAR_EVEN) ? (rx_par_reg ^ rxd_s) :
                    !(rx_par_reg ^ rxd_s);

   wire [8:0] rx_aligned = rx_sh_reg >> (4'h9 - char_bits);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rxd_prev_reg <= 1'b1;
      end else begin
         rxd_prev_reg <= rxd_s;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rx_state_reg       <= RX_IDLE;
         rx_ovs_reg         <= '0;
         rx_cnt_reg         <= '0;
         rx_sh_reg          <= '0;
         rx_par_reg         <= 1'b0;
         rx_stop2_reg       <= 1'b0;
         rx_unread_reg      <= 1'b0;
         rx_buffer_word     <= RX_BUF_RESET;
         async_error_status <= '0;
         rx_done_irq        <= 1'b0;
      end else begin
         rx_done_irq <= 1'b0;
         if (rx_buffer_read) begin
            async_error_status <= '0;
            rx_unread_reg      <= 1'b0;
         end
         if (serial_tick && rx_state_reg != RX_IDLE) begin
            rx_ovs_reg <= rx_ovs_reg + 4'h1;
         end
         if (!rx_enable) begin
            rx_state_reg <= RX_IDLE;
            rx_ovs_reg   <= '0;
         end else begin
            case (rx_state_reg)
               RX_IDLE: begin
                  if (rx_fall) begin
                     rx_ovs_reg   <= '0;
                     rx_state_reg <= RX_START;
                  end
               end
               RX_START: begin
                  if (rx_sample) begin
                     if (rxd_s) begin
                        rx_ovs_reg   <= '0;
                        rx_state_reg <= RX_IDLE;
                     end else begin
                        rx_cnt_reg   <= char_bits - 4'h1;
                        rx_par_reg   <= 1'b0;
                        rx_sh_reg    <= '0;
                        rx_stop2_reg <= async_mode_reg.stop_length_sel;
                        rx_state_reg <= RX_DATA;
                     end
                  end
               end
               RX_DATA: begin
                  if (rx_sample) begin
                     rx_sh_reg  <= {rxd_s, rx_sh_reg[8:1]};
                     rx_par_reg <= rx_par_reg ^ rxd_s;
                     rx_cnt_reg <= rx_cnt_reg - 4'h1;
                     if (rx_cnt_reg == 4'h0) begin
                        rx_state_reg <= par_on ? RX_PARITY : RX_STOP;
                     end
                  end
               end
               RX_PARITY: begin
                  if (rx_sample) begin
                     rx_par_reg   <= par_bad;
                     rx_state_reg <= RX_STOP;
                  end
               end
               RX_STOP: begin
                  if (rx_sample) begin
                     if (rx_stop2_reg && rxd_s) begin
                        rx_stop2_reg <= 1'b0;
                     end else begin
                        rx_buffer_word <= rx_aligned & char_mask(char_bits);
                        rx_unread_reg  <= 1'b1;
                        rx_done_irq    <= 1'b1;
                        async_error_status.parity_err_flag  <= par_on && rx_par_reg;
                        async_error_status.framing_err_flag <= !rxd_s;
                        async_error_status.overrun_err_flag <= rx_unread_reg
                                                               && !rx_buffer_read;
                        rx_ovs_reg   <= '0;
                        rx_state_reg <= RX_IDLE;
                     end
                  end
               end
               default: rx_state_reg <= RX_IDLE;
            endcase
         end
      end
   end

   assign rx_buffer_low_byte = rx_buffer_word[7:0];

   assign rx_error_irq = rx_enable && rx_done_irq
                         && (|async_error_status);

   assign irq_top_priority = rx_error_irq ? 2'h1 :
                             rx_done_irq  ? 2'h2 :
                             tx_done_irq  ? 2'h3 : 2'h0;

endmodule

`default_nettype wire

/* verif/uart_engine_assertions.sv */
// Purpose: port-level temporal checks for the async serial engine
// Assumes: one clock domain, synchronous active-high reset
// Notes:   rx error interrupt rises in the same cycle as rx done
`timescale 1ns/1ps
`default_nettype none
module uart_engine_checker
   import uart_pkg::*;
(
   // clock and reset
   input wire logic         ref_clk,
   input wire logic         reset,
   // configuration
   input wire async_mode_t  async_mode_reg,
   input wire logic         serial_tick,
   // transmit word
   input wire logic         tx_write,
   input wire logic [8:0]   tx_shift_word,
   input wire logic         tx_write_ready,
   input wire logic         tx_busy,
   // receive buffer
   input wire logic         rx_buffer_read,
   input wire logic [8:0]   rx_buffer_word,
   input wire logic [7:0]   rx_buffer_low_byte,
   input wire async_error_t async_error_status,
   // interrupts
   input wire logic         tx_done_irq,
   input wire logic         rx_done_irq,
   input wire logic         rx_error_irq,
   input wire logic [1:0]   irq_top_priority,
   // serial line
   input wire logic         txd,
   input wire logic         rxd
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   wire logic rx_on = async_mode_reg.rx_enable_bit;
   wire logic nine = async_mode_reg.ninth_bit_enable && async_mode_reg.parity_select == PAR_NONE;
   logic      unread_reg;

   // a character sits in the buffer until software reads it
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         unread_reg <= 1'b0;
      end else if (rx_buffer_read) begin
         unread_reg <= 1'b0;
      end else if (rx_done_irq) begin
         unread_reg <= 1'b1;
      end
   end

   tx_idle_high_a: assert property (!tx_busy |-> txd)
      else $error("txd low while transmitter idle");
   start_bit_a: assert property ($rose(tx_busy) |=> !txd)
      else $error("frame did not open with a start bit");
   tx_pulse_a: assert property (tx_done_irq |-> $past(tx_busy) ##1 !tx_done_irq)
      else $error("tx done not a single pulse after a frame");
   reset_quiet_a: assert property (disable iff (1'b0)
      reset |=> !tx_done_irq && txd && !tx_busy)
      else $error("reset did not silence the transmitter");
   rx_quiet_a: assert property (!rx_on && !$past(rx_on) |-> !rx_done_irq && !rx_error_irq)
      else $error("receive interrupt while receiver disabled");
   buf_hold_a: assert property ($changed(rx_buffer_word) |-> ##[0:1] rx_done_irq)
      else $error("buffer changed without rx done");
   upper_zero_a: assert property (rx_done_irq && !nine |-> !rx_buffer_word[8]
      && (async_mode_reg.char_length_sel || !rx_buffer_word[7]))
      else $error("unused buffer bits not zero");
   err_or_a: assert property (rx_done_irq && (|async_error_status) |-> ##[0:1] rx_error_irq)
      else $error("rx error interrupt missing for flagged frame");
   clear_read_a: assert property (rx_buffer_read && !rx_done_irq
      |=> async_error_status == '0 || rx_done_irq)
      else $error("error flags not cleared by buffer read");
   overrun_a: assert property (rx_done_irq && unread_reg && !rx_buffer_read
      |-> async_error_status.overrun_err_flag)
      else $error("overrun not flagged");
   prio_a: assert property (irq_top_priority == (rx_error_irq ? 2'h1 : rx_done_irq ? 2'h2 :
      tx_done_irq ? 2'h3 : 2'h0))
      else $error("wrong top priority code");

   cover property (tx_done_irq);
   cover property (rx_done_irq && async_error_status.parity_err_flag);
   cover property (rx_done_irq && async_error_status.overrun_err_flag);
endmodule

bind async_serial_uart_engine uart_engine_checker chk (
   .ref_clk, .reset, .async_mode_reg, .serial_tick, .tx_write, .tx_shift_word,
   .tx_write_ready, .tx_busy, .rx_buffer_read, .rx_buffer_word, .rx_buffer_low_byte,
   .async_error_status, .tx_done_irq, .rx_done_irq, .rx_error_irq, .irq_top_priority,
   .txd, .rxd
);
`default_nettype wire

/* verif/remote_serial_peer.sv */
// Purpose: remote asynchronous serial device on txd and rxd
// Assumes: caller enters tasks at a rising edge; 16 clocks per bit
// Notes:   line idles high as if pulled up
`timescale 1ns/1ps
`default_nettype none
module remote_serial_peer (
   // clock
   input wire logic ref_clk,
   // serial line
   input wire logic txd,
   output var logic rxd
);
   initial rxd = 1'b1;

   task automatic send(input logic [12:0] frm, input int n);
      for (int i = 0; i < n; i++) begin
         rxd <= frm[i];
         repeat (16) @(posedge ref_clk);
      end
      rxd <= 1'b1;
   endtask

   // short low pulse, far shorter than half a bit
   task automatic glitch();
      rxd <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rxd <= 1'b1;
      repeat (40) @(posedge ref_clk);
   endtask

   task automatic catch_frame(input int n, output logic [12:0] cap);
      cap = '1;
      while (txd !== 1'b0) @(posedge ref_clk);
      repeat (8) @(posedge ref_clk);
      for (int i = 0; i < n; i++) begin
         cap[i] = txd;
         repeat (16) @(posedge ref_clk);
      end
   endtask
endmodule
`default_nettype wire

/* verif/async_serial_uart_engine_tb.sv */
// Purpose: self-checking bench for the async serial engine
// Assumes: serial_tick tied high, so one bit lasts 16 clocks
// Notes:   one task per scenario; the peer plays the far end of the line
`timescale 1ns/1ps
`default_nettype none
module async_serial_uart_engine_tb
   import uart_pkg::*;
;
   logic         ref_clk;
   logic         reset;
   logic         tx_write;
   logic         rx_buffer_read;
   logic [8:0]   tx_shift_word;
   async_mode_t  mode;
   wire logic    tx_write_ready, tx_busy, tx_done_irq, rx_done_irq, rx_error_irq, txd, rxd;
   wire logic [8:0] rx_buffer_word;
   wire logic [7:0] rx_buffer_low_byte;
   wire logic [1:0] irq_top_priority;
   wire async_error_t async_error_status;
   int           failures;
   int           n_tests;

   async_serial_uart_engine uut (
      .ref_clk, .reset, .async_mode_reg(mode), .serial_tick(1'b1), .tx_write,
      .tx_shift_word, .tx_write_ready, .tx_busy, .rx_buffer_read, .rx_buffer_word,
      .rx_buffer_low_byte, .async_error_status, .tx_done_irq, .rx_done_irq,
      .rx_error_irq, .irq_top_priority, .txd, .rxd
   );
   remote_serial_peer peer (.ref_clk, .txd, .rxd);

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic check(input string what, input logic [12:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      if (failures == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   function automatic int nbits();
      if (mode.ninth_bit_enable && mode.parity_select == PAR_NONE) return 9;
      return mode.char_length_sel ? 8 : 7;
   endfunction

   // builds the line image; fp flips parity, bs breaks the first stop bit
   function automatic logic [12:0] mk(input logic [8:0] d, input logic fp, bs, output int n);
      logic [12:0] f;
      int          nb;
      logic        p;
      nb = nbits();
      f = '1;
      f[0] = 1'b0;
      p = 1'b0;
      for (int i = 0; i < nb; i++) begin
         f[i+1] = d[i];
         p ^= d[i];
      end
      n = nb + 2 + int'(mode.stop_length_sel);
      if (mode.parity_select != PAR_NONE) begin
         f[nb+1] = fp ^ (mode.parity_select == PAR_ODD ? ~p :
                         mode.parity_select == PAR_EVEN ? p : 1'b0);
         n++;
      end
      f[n-1-int'(mode.stop_length_sel)] = ~bs;
      return f;
   endfunction

   task automatic set_mode(input logic en, input logic [1:0] ps, input logic cl, sl, nine);
      @(posedge ref_clk);
      mode <= '{en, ps, cl, sl, nine};
      repeat (4) @(posedge ref_clk);
   endtask

   task automatic tx_frame(input logic [8:0] d);
      logic [12:0] f, cap;
      int          n;
      logic        done, low;
      f = mk(d, 1'b0, 1'b0, n);
      done = 1'b0;
      low = 1'b0;
      @(posedge ref_clk);
      tx_shift_word <= d;
      tx_write <= 1'b1;
      @(posedge ref_clk);
      tx_write <= 1'b0;
      fork
         peer.catch_frame(n, cap);
         begin
            // a write in mid-frame must vanish
            repeat (40) @(posedge ref_clk);
            tx_shift_word <= ~d;
            tx_write <= 1'b1;
            @(posedge ref_clk);
            tx_write <= 1'b0;
            for (int c = 0; c < n * 16 && done !== 1'b1; c++) begin
               @(posedge ref_clk);
               #1;
               done = tx_done_irq;
            end
         end
      join
      repeat (48) begin
         @(posedge ref_clk);
         #1;
         low = low | (txd !== 1'b1);
      end
      check("tx frame", cap, f);
      check("tx done", done, 1'b1);
      check("tx idle", low, 1'b0);
      check("tx ready", tx_write_ready, 1'b1);
   endtask

   task automatic rx_frame(input logic [8:0] d, input logic fp, bs, rd, input logic [2:0] ef);
      logic [12:0] f;
      int          n;
      logic        got, err;
      f = mk(d, fp, bs, n);
      got = 1'b0;
      err = 1'b0;
      fork
         peer.send(f, n);
         for (int c = 0; c < n * 16 + 40; c++) begin
            @(posedge ref_clk);
            #1;
            err = err | (rx_error_irq === 1'b1);
            if (rx_done_irq === 1'b1) begin
               got = 1'b1;
               check("rx word", rx_buffer_word, d & (9'h1FF >> (9 - nbits())));
               check("low byte", rx_buffer_low_byte, 8'(d & (9'h1FF >> (9 - nbits()))));
               check("rx flags", async_error_status, ef);
            end
         end
      join
      check("rx done", got, 1'b1);
      check("rx error irq", err, |ef);
      // flags are read before the buffer
      if (rd) begin
         @(posedge ref_clk);
         rx_buffer_read <= 1'b1;
         @(posedge ref_clk);
         rx_buffer_read <= 1'b0;
         @(posedge ref_clk);
         #1;
         check("flags after read", async_error_status, 3'h0);
      end
   endtask

   // errored frame, aborted by disabling mid-way
   task automatic rx_abort(input logic [8:0] prev);
      logic [12:0] f;
      int          n;
      logic        seen;
      f = mk(9'h0C3, 1'b1, 1'b1, n);
      seen = 1'b0;
      fork
         peer.send(f, n);
         begin
            repeat (60) @(posedge ref_clk);
            mode.rx_enable_bit <= 1'b0;
            repeat (n * 16) begin
               @(posedge ref_clk);
               #1;
               seen = seen | (rx_done_irq !== 1'b0) | (rx_error_irq !== 1'b0);
            end
         end
      join
      check("irq while disabled", seen, 1'b0);
      check("buffer kept", rx_buffer_word, prev);
      check("flags kept", async_error_status, 3'h0);
      set_mode(1'b1, PAR_ODD, 1'b0, 1'b0, 1'b0);
   endtask

   task automatic tx_reset();
      logic seen;
      seen = 1'b0;
      @(posedge ref_clk);
      tx_shift_word <= 9'h0F0;
      tx_write <= 1'b1;
      @(posedge ref_clk);
      tx_write <= 1'b0;
      repeat (60) @(posedge ref_clk);
      reset <= 1'b1;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (300) begin
         @(posedge ref_clk);
         #1;
         seen = seen | (tx_done_irq !== 1'b0) | (txd !== 1'b1);
      end
      check("quiet after reset", seen, 1'b0);
   endtask

   // about 3700 clocks of traffic expected; generous margin
   initial begin
      repeat (60000) @(posedge ref_clk);
      failures++;
      summarize();
   end

   initial begin
      reset = 1'b1;
      tx_write = 1'b0;
      rx_buffer_read = 1'b0;
      tx_shift_word = 9'h000;
      mode = '{1'b1, PAR_NONE, 1'b1, 1'b0, 1'b0};
      failures = 0;
      n_tests = 0;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      tx_frame(9'h0A5);
      set_mode(1'b1, PAR_EVEN, 1'b1, 1'b1, 1'b0);
      tx_frame(9'h03C);
      set_mode(1'b1, PAR_NONE, 1'b1, 1'b1, 1'b1);
      tx_frame(9'h155);
      for (int p = 0; p < 4; p++) begin
         set_mode(1'b1, 2'(p), 1'b1, 1'b0, 1'b1);
         rx_frame(9'h1B4, 1'b0, 1'b0, 1'b1, 3'h0);
         if (p != 0) rx_frame(9'h06D, 1'b1, 1'b0, 1'b1, 3'h4);
      end
      set_mode(1'b1, PAR_ODD, 1'b0, 1'b0, 1'b0);
      rx_frame(9'h1FF, 1'b0, 1'b1, 1'b1, 3'h2);
      rx_frame(9'h011, 1'b0, 1'b0, 1'b0, 3'h0);
      rx_frame(9'h022, 1'b0, 1'b0, 1'b1, 3'h1);
      peer.glitch();
      rx_frame(9'h04E, 1'b0, 1'b0, 1'b1, 3'h0);
      rx_abort(9'h04E);
      tx_reset();
      summarize();
   end
endmodule
`default_nettype wire
